// *** shared/bscan_map.vh ***
`ifndef BSCAN_MAP_VH
`define BSCAN_MAP_VH

// ----------------------------------------------------------------
// Cell geometry.
// ----------------------------------------------------------------
`define CELL_BITS 3
`define CAP_OUT_BIT 2
`define CAP_OE_BIT 1
`define CAP_IN_BIT 0

// ----------------------------------------------------------------
// Pin classes, three bits each in the class vector.
// ----------------------------------------------------------------
`define CLASS_W 3
`define CLASS_USER_IO 3'h0
`define CLASS_DED_INPUT 3'h1
`define CLASS_DED_OPEN_DRAIN 3'h2
`define CLASS_DED_BIDIR 3'h3
`define CLASS_DED_OUTPUT 3'h4

// ----------------------------------------------------------------
// Edge event word and buffer.
// ----------------------------------------------------------------
`define EV_W 5
`define EV_FALL_BIT 4
`define EV_TDI_BIT 3
`define EV_SHIFT_BIT 2
`define EV_CAPTURE_BIT 1
`define EV_UPDATE_BIT 0
`define EV_FIFO_DEPTH 16
`define EV_FIFO_AW 4

// ----------------------------------------------------------------
// Link-side input synchroniser bit positions.
// ----------------------------------------------------------------
`define SY_W 6
`define SY_TCK 5
`define SY_TDI 4
`define SY_SHIFT 3
`define SY_CAPTURE 2
`define SY_UPDATE 1
`define SY_MODE 0

`endif

// *** sim/chain_checker_assertions.sv ***
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------------------------
// Port checks for the scan chain.
// ------------------------------------------------------------
module chain_checker #(
  parameter N_CELLS = 4,
  parameter [3*N_CELLS-1:0] CELL_CLASSES = 12'h000
) (
  // Clock and reset.
  input wire ref_clk,
  input wire srst,
  // Link and mode.
  input wire tck,
  input wire mode_test,
  input wire tdo_q,
  input wire tdo_oe_q,
  input wire obs_valid_q,
  // Core and pins.
  input wire [N_CELLS-1:0] core_out_data,
  input wire [N_CELLS-1:0] core_out_enable,
  input wire [N_CELLS-1:0] core_in_value_q,
  input wire [N_CELLS-1:0] pin_in,
  input wire [N_CELLS-1:0] pin_out_q,
  input wire [N_CELLS-1:0] pin_oe_q
);
  logic tck_d;
  logic [4:0] rise_n;
  logic [4:0] fall_n;
  logic [1:0] up_n;
  wire logic [N_CELLS-1:0] ded;
  genvar g;
  for (g = 0; g < N_CELLS; g = g + 1) begin : g_ded
    assign ded[g] = CELL_CLASSES[3*g+:3] != 3'h0;
  end
  always_ff @(posedge ref_clk) begin
    tck_d <= tck;
    if (srst) begin
      rise_n <= 5'h1F;
      fall_n <= 5'h1F;
      up_n <= 2'h0;
    end else begin
      if (tck && !tck_d) rise_n <= 5'h00;
      else if (rise_n != 5'h1F) rise_n <= rise_n + 5'h01;
      if (!tck && tck_d) fall_n <= 5'h00;
      else if (fall_n != 5'h1F) fall_n <= fall_n + 5'h01;
      if (up_n != 2'h3) up_n <= up_n + 2'h1;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  tdo_fall_a: assert property ($changed(tdo_q) |-> fall_n <= 5'h0A)
    else $error("tdo moved off a tck fall");
  oe_fall_a: assert property ($changed(tdo_oe_q) |-> fall_n <= 5'h0A)
    else $error("tdo enable moved off a tck fall");
  shift_rise_a: assert property (
    $rose(obs_valid_q) |-> rise_n <= 5'h0C)
    else $error("shift off a tck rise");
  func_out_a: assert property (
    (!mode_test)[*6] ##0 up_n == 2'h3 |-> pin_out_q == $past(core_out_data))
    else $error("pin out not passed through");
  func_in_a: assert property (
    ($stable(pin_in) && !mode_test)[*6] ##0 up_n == 2'h3
    |-> core_in_value_q == pin_in)
    else $error("core input not passed through");
  ded_out_a: assert property (
    up_n == 2'h3 |-> (pin_out_q & ded) == ($past(core_out_data) & ded))
    else $error("dedicated pin drive disturbed");
  ded_oe_a: assert property (
    up_n == 2'h3 |-> (pin_oe_q & ded) == ($past(core_out_enable) & ded))
    else $error("dedicated enable disturbed");
  upd_fall_a: assert property (
    mode_test[*8] ##0 $changed({pin_out_q & ~ded, pin_oe_q & ~ded})
    |-> fall_n <= 5'h0A)
    else $error("user pin moved off an update fall");
  cover property ($rose(tdo_oe_q));
  cover property (mode_test && $changed(pin_out_q));
  cover property ($rose(obs_valid_q));
endmodule

bind boundary_scan_cell_chain chain_checker #(
  .N_CELLS(N_CELLS), .CELL_CLASSES(CELL_CLASSES)) chain_checker_i (
  .ref_clk(ref_clk), .srst(srst), .tck(tck), .mode_test(mode_test),
  .tdo_q(tdo_q), .tdo_oe_q(tdo_oe_q), .obs_valid_q(obs_valid_q),
  .core_out_data(core_out_data), .core_in_value_q(core_in_value_q),
  .core_out_enable(core_out_enable),
  .pin_in(pin_in), .pin_out_q(pin_out_q), .pin_oe_q(pin_oe_q));
`default_nettype wire

// *** sim/scan_tester.sv ***
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------------------------
// Tester on the link; tck stands low between frames.
// ------------------------------------------------------------
module scan_tester (
  // Link to the chain.
  output logic tck,
  output logic tdi,
  output logic shift_dr,
  output logic capture_dr,
  output logic update_dr,
  input wire logic tdo_q,
  input wire logic tdo_oe_q
);
  logic oe_seen = 1'b0;
  initial begin
    tck = 1'b0;
    tdi = 1'b1;
    shift_dr = 1'b0;
    capture_dr = 1'b0;
    update_dr = 1'b0;
  end
  task automatic tick();
    #62.5;
    tck = 1'b1;
    #62.5;
    tck = 1'b0;
  endtask
  task automatic pulse(input logic upd);
    capture_dr = !upd;
    update_dr = upd;
    tdi = ~tdi;
    tick();
    capture_dr = 1'b0;
    if (upd) #31.25;
    update_dr = 1'b0;
  endtask
  task automatic scan(input int n, input logic [31:0] din,
    output logic [31:0] dout);
    oe_seen = 1'b1;
    shift_dr = 1'b1;
    for (int k = 0; k < n; k++) begin
      tdi = din[k];
      #62.5;
      dout[k] = tdo_oe_q ? tdo_q : ~tdo_q;
      if (k > 0) oe_seen = oe_seen & tdo_oe_q;
      tck = 1'b1;
      #62.5;
      tck = 1'b0;
    end
    shift_dr = 1'b0;
    tdi = ~tdi;
  endtask
endmodule
`default_nettype wire

// *** sim/tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------------------------
// Scenarios for the scan chain.
// ------------------------------------------------------------
module tb_top;
  localparam int N = 5;
  localparam logic [14:0] CLS = 15'h4688;
  logic ref_clk, srst, clk_en, mode_test, obs_ready;
  logic tck, tdi, shift_dr, capture_dr, update_dr;
  logic tdo_q, tdo_oe_q, obs_valid_q, obs_data_q, overrun_q;
  logic [N-1:0] cod, coe, pin, cin, pout, poe;
  logic [31:0] dout;
  int err_count = 0;
  int tests_run = 0;
  boundary_scan_cell_chain #(.N_CELLS(N), .CELL_CLASSES(CLS))
    boundary_scan_cell_chain_i (.ref_clk(ref_clk), .srst(srst),
    .clk_en(clk_en), .tck(tck), .tdi(tdi), .shift_dr(shift_dr),
    .capture_dr(capture_dr), .update_dr(update_dr), .mode_test(mode_test),
    .tdo_q(tdo_q), .tdo_oe_q(tdo_oe_q), .core_out_data(cod),
    .core_out_enable(coe), .core_in_value_q(cin), .pin_in(pin),
    .pin_out_q(pout), .pin_oe_q(poe), .obs_valid_q(obs_valid_q),
    .obs_data_q(obs_data_q), .obs_ready(obs_ready), .overrun_q(overrun_q));
  scan_tester scan_tester_i (.tck(tck), .tdi(tdi), .shift_dr(shift_dr),
    .capture_dr(capture_dr), .update_dr(update_dr), .tdo_q(tdo_q),
    .tdo_oe_q(tdo_oe_q));
  task automatic chk(input string what, input logic [31:0] exp,
    input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  function automatic logic [14:0] cap_exp();
    logic [2:0] c;
    cap_exp = '0;
    for (int i = 0; i < N; i++) begin
      c = CLS[3*i+:3];
      cap_exp[3*i+2] = (c == 3'h1 || c == 3'h2) ? 1'b0 : cod[i];
      cap_exp[3*i+1] = (c == 3'h1) ? 1'b1 : (c == 3'h4) ? 1'b0 : coe[i];
      cap_exp[3*i] = (c == 3'h4) ? 1'b0 : pin[i];
    end
  endfunction
  task automatic t_functional();
    for (int k = 0; k < 2; k++) begin
      settle(1);
      mode_test = 1'b0;
      cod = k ? 5'h0A : 5'h15;
      coe = k ? 5'h13 : 5'h0C;
      pin = k ? 5'h19 : 5'h06;
      settle(8);
      chk("pin_out", cod, pout);
      chk("pin_oe", coe, poe);
      chk("core_in", pin, cin);
    end
    $display("t_functional done");
  endtask
  task automatic t_capture();
    logic [14:0] p;
    for (int k = 0; k < 2; k++) begin
      settle(1);
      cod = k ? 5'h12 : 5'h0D;
      coe = ~cod;
      pin = k ? 5'h07 : 5'h1B;
      p = k ? 15'h2C5A : 15'h13A5;
      settle(8);
      scan_tester_i.pulse(1'b0);
      scan_tester_i.scan(30, {17'h0, p}, dout);
      scan_tester_i.pulse(1'b1);
      chk("cap", cap_exp(), dout[14:0]);
      chk("loop", p, dout[29:15]);
      chk("oe in shift", 1'b1, scan_tester_i.oe_seen);
      settle(8);
      chk("oe after", 1'b0, tdo_oe_q);
    end
    $display("t_capture done");
  endtask
  task automatic t_update();
    logic [14:0] d;
    for (int k = 0; k < 2; k++) begin
      d = k ? 15'h6AB2 : 15'h1545;
      settle(1);
      mode_test = 1'b1;
      scan_tester_i.scan(15, {17'h0, d}, dout);
      scan_tester_i.pulse(1'b1);
      settle(8);
      chk("user out", d[2], pout[0]);
      chk("user oe", !d[1], poe[0]);
      chk("user in", d[0], cin[0]);
      chk("ded out", cod[4:1], pout[4:1]);
      chk("ded oe", coe[4:1], poe[4:1]);
      chk("ded in", pin[4:1], cin[4:1]);
    end
    $display("t_update done");
  endtask
  task automatic t_overrun();
    settle(1);
    obs_ready = 1'b0;
    scan_tester_i.pulse(1'b0);
    scan_tester_i.scan(20, 32'h0, dout);
    settle(8);
    chk("overrun", 1'b1, overrun_q);
    chk("obs valid", 1'b1, obs_valid_q);
    chk("obs data", pin[0], obs_data_q);
    srst = 1'b1;
    settle(2);
    srst = 1'b0;
    obs_ready = 1'b1;
    chk("overrun clear", 1'b0, overrun_q);
    $display("t_overrun done");
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  initial begin
    #200000;
    err_count++;
    finish_test();
  end
  initial begin
    srst = 1'b1;
    clk_en = 1'b1;
    mode_test = 1'b0;
    obs_ready = 1'b1;
    cod = '0;
    coe = '0;
    pin = '0;
    settle(5);
    srst = 1'b0;
    settle(4);
    t_functional();
    t_capture();
    t_update();
    t_functional();
    t_overrun();
    finish_test();
  end
endmodule
`default_nettype wire

// *** verilog/boundary_scan_cell_chain.v ***
`timescale 1ns/10ps
`default_nettype none
`include "bscan_map.vh"

// Operation
// [RQ1] One serial chain from test input to output.
// [RQ2] Each scanned pin adds a three-bit cell.
// [RQ3] Cells capture core data, enable and pin.
// [RQ4] User I/O update bits drive pin and core.
// [RQ5] Shift, capture, update come from TAP logic.
// [RQ6] Mode select comes from instruction decode.
// [RQ7] Serial data passes cell in to out.
// [RQ8] Dedicated inputs capture 0, 1, pin.
// [RQ9] Open-drain pins capture 0, enable, pin.
// [RQ10] Push-pull dedicated pins capture all, drive none.
// [RQ11] Dedicated outputs capture data, then 0, 0.
// [RQ12] Test, power, reference, thermal pins have no cell.
// [RQ13] Chain shifts test input on clock rise.
// [RQ14] Test output changes on clock fall.
// [RQ15] Update copies capture bits on update.
// [RQ16] Enable update bit 1 tri-states user pin.
// [RQ17] Cell order and count are parameters.
// [RQ18] Functional mode passes signals through unchanged.
module boundary_scan_cell_chain #(
  parameter N_CELLS = 4,
  parameter [3*N_CELLS-1:0] CELL_CLASSES = 12'h000
) (
  // Clock, reset and enable.
  input wire ref_clk,
  input wire srst,
  input wire clk_en,
  // Test link from the tester and TAP logic.
  input wire tck,
  input wire tdi,
  input wire shift_dr,
  input wire capture_dr,
  input wire update_dr,
  input wire mode_test,
  output reg tdo_q,
  output reg tdo_oe_q,
  // Core side, one bit per scanned pin.
  input wire [N_CELLS-1:0] core_out_data,
  input wire [N_CELLS-1:0] core_out_enable,
  output reg [N_CELLS-1:0] core_in_value_q,
  // Pin side, one bit per scanned pin.
  input wire [N_CELLS-1:0] pin_in,
  output reg [N_CELLS-1:0] pin_out_q,
  output reg [N_CELLS-1:0] pin_oe_q,
  // Shifted-out bit stream and buffer status.
  output reg obs_valid_q,
  output reg obs_data_q,
  input wire obs_ready,
  output reg overrun_q
);

  // ----------------------------------------------------------------
  // Synchronisers for everything from the test clock side.
  // ----------------------------------------------------------------
  reg [`SY_W-1:0] sy1_q;
  reg [`SY_W-1:0] sy2_q;
  reg [N_CELLS-1:0] pin1_q;
  reg [N_CELLS-1:0] pin2_q;
  reg tck_prev_q;
  wire tck_rise;
  wire tck_fall;

  always @(posedge ref_clk) begin
    if (srst) begin
      sy1_q <= {`SY_W{1'b0}};
      sy2_q <= {`SY_W{1'b0}};
      pin1_q <= {N_CELLS{1'b0}};
      pin2_q <= {N_CELLS{1'b0}};
      tck_prev_q <= 1'b0;
    end else if (clk_en) begin
      sy1_q <= {tck, tdi, shift_dr, capture_dr, update_dr, mode_test};
      sy2_q <= sy1_q;
      pin1_q <= pin_in;
      pin2_q <= pin1_q;
      tck_prev_q <= sy2_q[`SY_TCK];
    end
  end

  assign tck_rise = sy2_q[`SY_TCK] & ~tck_prev_q;
  assign tck_fall = ~sy2_q[`SY_TCK] & tck_prev_q;

  // ----------------------------------------------------------------
  // Edge event buffer.
  // ----------------------------------------------------------------
  wire ev_in_valid;
  wire ev_in_ready;
  wire [`EV_W-1:0] ev_in_data;
  wire ev_valid;
  wire ev_ready;
  wire [`EV_W-1:0] ev_data;

  assign ev_in_valid = clk_en & (tck_rise | tck_fall);
  assign ev_in_data = {tck_fall, sy2_q[`SY_TDI], sy2_q[`SY_SHIFT],
    sy2_q[`SY_CAPTURE], sy2_q[`SY_UPDATE]}; // [RQ5]
  assign ev_ready = clk_en & ~(obs_valid_q & ~obs_ready);

  edge_event_fifo #(
    .WIDTH(`EV_W),
    .DEPTH(`EV_FIFO_DEPTH),
    .AW(`EV_FIFO_AW)
  ) u_ev_fifo (
    .ref_clk(ref_clk),
    .srst(srst),
    .clk_en(clk_en),
    .in_valid(ev_in_valid),
    .in_ready(ev_in_ready),
    .in_data(ev_in_data),
    .out_valid_q(ev_valid),
    .out_ready(ev_ready),
    .out_data_q(ev_data)
  );

  // ----------------------------------------------------------------
  // Event decode into cell strobes.
  // ----------------------------------------------------------------
  wire ev_take;
  wire ev_is_fall;
  wire ev_shift;
  wire ev_capture;
  wire ev_update;

  assign ev_take = ev_valid & ev_ready;
  assign ev_is_fall = ev_data[`EV_FALL_BIT];
  assign ev_capture = ev_take & ~ev_is_fall & ev_data[`EV_CAPTURE_BIT];
  assign ev_shift = ev_take & ~ev_is_fall & ev_data[`EV_SHIFT_BIT] &
    ~ev_data[`EV_CAPTURE_BIT]; // [RQ13]
  assign ev_update = ev_take & ev_is_fall & ev_data[`EV_UPDATE_BIT]; // [RQ15]

  // ----------------------------------------------------------------
  // Cell chain: the top cell takes the test input, cell 0 feeds out.
  // ----------------------------------------------------------------
  wire [N_CELLS:0] link;
  wire [N_CELLS-1:0] cell_pin_out;
  wire [N_CELLS-1:0] cell_pin_oe;
  wire [N_CELLS-1:0] cell_core_in;

  assign link[N_CELLS] = ev_data[`EV_TDI_BIT]; // [RQ1] [RQ12]

  genvar gi;
  generate
    for (gi = 0; gi < N_CELLS; gi = gi + 1) begin : g_cell // [RQ2] [RQ17]
      scan_cell #(
        .PIN_CLASS(CELL_CLASSES[3*gi +: 3])
      ) u_cell (
        .ref_clk(ref_clk),
        .srst(srst),
        .clk_en(clk_en),
        .ev_shift(ev_shift),
        .ev_capture(ev_capture),
        .ev_update(ev_update),
        .mode_test(sy2_q[`SY_MODE]), // [RQ6]
        .cell_serial_in(link[gi+1]),
        .cell_serial_out(link[gi]),
        .core_out_data(core_out_data[gi]),
        .core_out_enable(core_out_enable[gi]),
        .pin_in(pin2_q[gi]),
        .pin_out(cell_pin_out[gi]),
        .pin_oe(cell_pin_oe[gi]),
        .core_in_value(cell_core_in[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Registered outputs, test output and observation stream.
  // ----------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (srst) begin
      tdo_q <= 1'b0;
      tdo_oe_q <= 1'b0;
      pin_out_q <= {N_CELLS{1'b0}};
      pin_oe_q <= {N_CELLS{1'b0}};
      core_in_value_q <= {N_CELLS{1'b0}};
      obs_valid_q <= 1'b0;
      obs_data_q <= 1'b0;
      overrun_q <= 1'b0;
    end else if (clk_en) begin
      pin_out_q <= cell_pin_out;
      pin_oe_q <= cell_pin_oe;
      core_in_value_q <= cell_core_in;
      if (ev_take && ev_is_fall) begin
        tdo_q <= link[0]; // [RQ14] [RQ1]
        tdo_oe_q <= ev_data[`EV_SHIFT_BIT]; // [RQ14]
      end
      if (ev_shift) begin
        obs_valid_q <= 1'b1;
        obs_data_q <= link[0];
      end else if (obs_ready) begin
        obs_valid_q <= 1'b0;
      end
      if (ev_in_valid && !ev_in_ready) begin
        overrun_q <= 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// *** verilog/edge_event_fifo.v ***
`timescale 1ns/10ps
`default_nettype none

module edge_event_fifo #(
  parameter WIDTH = 5,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  // Clock and reset.
  input wire ref_clk,
  input wire srst,
  input wire clk_en,
  // Fill side.
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  // Drain side.
  output reg out_valid_q,
  input wire out_ready,
  output reg [WIDTH-1:0] out_data_q
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_q;
  reg [AW-1:0] rd_ptr_q;
  reg [AW:0] count_q;
  wire push;
  wire pop;

  assign in_ready = (count_q != DEPTH[AW:0]);
  assign push = in_valid & in_ready;
  assign pop = (count_q != {(AW+1){1'b0}}) & (~out_valid_q | out_ready);

  always @(posedge ref_clk) begin
    if (push && clk_en) begin
      mem[wr_ptr_q] <= in_data;
    end
  end

  always @(posedge ref_clk) begin
    if (srst) begin
      wr_ptr_q <= {AW{1'b0}};
      rd_ptr_q <= {AW{1'b0}};
      count_q <= {(AW+1){1'b0}};
      out_valid_q <= 1'b0;
      out_data_q <= {WIDTH{1'b0}};
    end else if (clk_en) begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
        out_data_q <= mem[rd_ptr_q];
        out_valid_q <= 1'b1;
      end else if (out_ready) begin
        out_valid_q <= 1'b0;
      end
      if (push && !pop) begin
        count_q <= count_q + 1'b1;
      end else if (pop && !push) begin
        count_q <= count_q - 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// *** verilog/scan_cell.v ***
`timescale 1ns/10ps
`default_nettype none
`include "bscan_map.vh"

module scan_cell #(
  parameter [2:0] PIN_CLASS = 3'h0
) (
  // Clock and reset.
  input wire ref_clk,
  input wire srst,
  input wire clk_en,
  // Chain controls.
  input wire ev_shift,
  input wire ev_capture,
  input wire ev_update,
  input wire mode_test,
  input wire cell_serial_in,
  output wire cell_serial_out,
  // Core and pin side.
  input wire core_out_data,
  input wire core_out_enable,
  input wire pin_in,
  output reg pin_out,
  output reg pin_oe,
  output reg core_in_value
);

  reg [2:0] cap_q;
  reg [2:0] upd_q;
  reg [2:0] cap_d;

  assign cell_serial_out = cap_q[0]; // [RQ7]

  // ----------------------------------------------------------------
  // Captured values per pin class.
  // ----------------------------------------------------------------
  always @* begin
    case (PIN_CLASS)
      `CLASS_DED_INPUT: cap_d = {1'b0, 1'b1, pin_in}; // [RQ8]
      `CLASS_DED_OPEN_DRAIN: cap_d = {1'b0, core_out_enable, pin_in}; // [RQ9]
      `CLASS_DED_BIDIR: cap_d = {core_out_data, core_out_enable, pin_in}; // [RQ10]
      `CLASS_DED_OUTPUT: cap_d = {core_out_data, 1'b0, 1'b0}; // [RQ11]
      default: cap_d = {core_out_data, core_out_enable, pin_in}; // [RQ3]
    endcase
  end

  always @(posedge ref_clk) begin
    if (srst) begin
      cap_q <= 3'h0;
      upd_q <= 3'h0;
    end else if (clk_en) begin
      if (ev_capture) begin
        cap_q <= cap_d;
      end else if (ev_shift) begin
        cap_q <= {cell_serial_in, cap_q[2:1]}; // [RQ7]
      end
      if (ev_update && PIN_CLASS == `CLASS_USER_IO) begin
        upd_q <= cap_q; // [RQ15]
      end
    end
  end

  // ----------------------------------------------------------------
  // Drive selection: update registers only steer user I/O cells.
  // ----------------------------------------------------------------
  always @* begin
    if (mode_test && PIN_CLASS == `CLASS_USER_IO) begin
      pin_out = upd_q[`CAP_OUT_BIT]; // [RQ4]
      pin_oe = ~upd_q[`CAP_OE_BIT]; // [RQ16]
      core_in_value = upd_q[`CAP_IN_BIT]; // [RQ4]
    end else begin
      pin_out = core_out_data; // [RQ18]
      pin_oe = core_out_enable; // [RQ18]
      core_in_value = pin_in; // [RQ18]
    end
  end

endmodule

`default_nettype wire
